// File: design/umf_modem_flow.sv
// Summary of operation
// - Set dsr and cts change flags when that line changed since last status read.
// - Raise modem interrupt while any of the four change flags is one.
// - Eight-bit scratch byte reads back as written, affecting nothing else.
// - With auto transmit gating, hold the transmitter while cts pin is one.
// - With auto transmit gating, release the transmitter once cts pin is zero.
// - With auto rts, flag an interrupt when receive fill reaches trigger level.
// - With auto rts, drive rts pin one at the next higher trigger level.
// - With auto rts, return rts pin to zero below the next lower level.
// - Outside loop-back and without auto rts, rts pin follows the software modem control bit only.
// - Auto cts and auto rts enables reset to zero.
// - Feature bits 0 to 3 choose single or dual character software flow.
// - Dual mode treats each pair of pause or resume bytes as one sequence.
// - Reading the modem line status clears all four change flags.
// - Cts status bit is inverted cts pin, or rts control bit in loop-back.
`timescale 1ns/1ps
`default_nettype none
module umf_modem_flow
(
    input  wire logic                           ref_clk_i,
    input  wire logic                           sys_rst_i,
    input  wire umf_pkg::umf_bus_req_s          bus_i,
    output logic      [7:0]                     rdata_o,
    input  wire logic                           cts_pin_i,
    input  wire logic                           dsr_pin_i,
    input  wire logic                           ri_pin_i,
    input  wire logic                           cd_pin_i,
    input  wire logic [umf_pkg::UMF_FILL_W-1:0] rx_fill_i,
    output logic                                rts_pin_o,
    output logic                                dtr_pin_o,
    output logic                                op1_pin_o,
    output logic                                op2_pin_o,
    output logic                                tx_hold_o,
    output logic                                modem_irq_o,
    output logic                                irq_o,
    output logic      [1:0]                     tx_sw_mode_o,
    output logic      [1:0]                     rx_sw_mode_o,
    output logic                                enh_enable_o,
    output logic      [15:0]                    resume_seq_o,
    output logic      [15:0]                    pause_seq_o
);
    import umf_pkg::*;

    logic [7:0]           scratch_reg;
    logic [7:0]           feature_reg;
    logic [7:0]           mcr_reg;
    logic [7:0]           resume_one_reg;
    logic [7:0]           resume_two_reg;
    logic [7:0]           pause_one_reg;
    logic [7:0]           pause_two_reg;
    logic [1:0]           trig_sel_reg;
    logic [3:0]           flag_reg;
    logic [3:0]           flag_next;
    logic [3:0]           line_prev_reg;
    logic [UMF_IRQ_W-1:0] irq_sts_reg;
    logic [UMF_IRQ_W-1:0] irq_en_reg;
    logic [UMF_IRQ_W-1:0] irq_evt;
    logic [7:0]           rdata_reg;
    logic                 rts_pin_reg;
    logic                 dtr_pin_reg;
    logic                 op1_pin_reg;
    logic                 op2_pin_reg;
    logic                 tx_hold_reg;
    logic                 trig_prev_reg;
    logic [3:0]           pin_level;
    logic [3:0]           line_act;
    logic [3:0]           chg_evt;
    logic                 loop_mode;
    logic                 status_rd;
    logic                 trig_hit;
    logic                 rts_hold;

    umf_pin_sync u_sync
    (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     ({cd_pin_i, ri_pin_i, dsr_pin_i, cts_pin_i}),
        .level_o   (pin_level)
    );

    umf_rts_ctrl u_rts
    (
        .ref_clk_i  (ref_clk_i),
        .sys_rst_i  (sys_rst_i),
        .enable_i   (feature_reg[UMF_FEAT_AUTO_RTS]),
        .trig_sel_i (trig_sel_reg),
        .fill_i     (rx_fill_i),
        .trig_hit_o (trig_hit),
        .hold_o     (rts_hold)
    );

    assign loop_mode = mcr_reg[UMF_MCR_LOOP];
    assign status_rd = bus_i.rd && (bus_i.addr == UMF_OFS_MODEM_STATUS);

    // asserted sense of each line; loop-back feeds the control bits back in
    always_comb
    begin
        if (loop_mode)
        begin
            line_act[UMF_LN_CTS] = mcr_reg[UMF_MCR_RTS];
            line_act[UMF_LN_DSR] = mcr_reg[UMF_MCR_DTR];
            line_act[UMF_LN_RI]  = mcr_reg[UMF_MCR_OP1];
            line_act[UMF_LN_CD]  = mcr_reg[UMF_MCR_OP2];
        end
        else
        begin
            line_act = ~pin_level;
        end
    end

    // ring only reports its trailing edge; the rest report any change
    always_comb
    begin
        chg_evt = line_act ^ line_prev_reg;
        chg_evt[UMF_LN_RI] = line_prev_reg[UMF_LN_RI] && !line_act[UMF_LN_RI];
    end

    // a change landing in the read cycle survives the clear
    assign flag_next = (status_rd ? 4'h0 : flag_reg) | chg_evt;

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            line_prev_reg <= 4'h0;
            flag_reg      <= 4'h0;
        end
        else
        begin
            line_prev_reg <= line_act;
            flag_reg      <= flag_next;
        end
    end

    assign modem_irq_o = |flag_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            scratch_reg <= UMF_SCRATCH_RST;
        end
        else if (bus_i.wr && bus_i.addr == UMF_OFS_SCRATCH)
        begin
            scratch_reg <= bus_i.wdata;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            feature_reg <= UMF_ZERO8;
        end
        else if (bus_i.wr && bus_i.addr == UMF_OFS_ENH_FEATURE)
        begin
            feature_reg <= bus_i.wdata;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            mcr_reg      <= UMF_ZERO8;
            trig_sel_reg <= 2'h0;
        end
        else if (bus_i.wr)
        begin
            if (bus_i.addr == UMF_OFS_MODEM_CTRL)
            begin
                mcr_reg <= {3'h0, bus_i.wdata[4:0]};
            end
            if (bus_i.addr == UMF_OFS_FIFO_CTRL)
            begin
                trig_sel_reg <= bus_i.wdata[1:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            resume_one_reg <= UMF_ZERO8;
            resume_two_reg <= UMF_ZERO8;
            pause_one_reg  <= UMF_ZERO8;
            pause_two_reg  <= UMF_ZERO8;
        end
        else if (bus_i.wr)
        begin
            if (bus_i.addr == UMF_OFS_RESUME_ONE)
            begin
                resume_one_reg <= bus_i.wdata;
            end
            if (bus_i.addr == UMF_OFS_RESUME_TWO)
            begin
                resume_two_reg <= bus_i.wdata;
            end
            if (bus_i.addr == UMF_OFS_PAUSE_ONE)
            begin
                pause_one_reg <= bus_i.wdata;
            end
            if (bus_i.addr == UMF_OFS_PAUSE_TWO)
            begin
                pause_two_reg <= bus_i.wdata;
            end
        end
    end

    // software flow selection is handed to the character engines as raw register fields
    assign tx_sw_mode_o = feature_reg[3:2];
    assign rx_sw_mode_o = feature_reg[1:0];
    assign enh_enable_o = feature_reg[UMF_FEAT_ENH_EN];
    // first character is sent or matched first
    assign resume_seq_o = {resume_one_reg, resume_two_reg};
    assign pause_seq_o  = {pause_one_reg, pause_two_reg};

    assign irq_evt[UMF_IRQ_MODEM]  = |chg_evt;
    assign irq_evt[UMF_IRQ_RXTRIG] = trig_hit && !trig_prev_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            irq_sts_reg   <= '0;
            irq_en_reg    <= '0;
            trig_prev_reg <= 1'b0;
        end
        else
        begin
            trig_prev_reg <= trig_hit;
            if (bus_i.wr && bus_i.addr == UMF_OFS_IRQ_CLEAR)
            begin
                irq_sts_reg <= (irq_sts_reg & ~bus_i.wdata[UMF_IRQ_W-1:0]) | irq_evt;
            end
            else
            begin
                irq_sts_reg <= irq_sts_reg | irq_evt;
            end
            if (bus_i.wr && bus_i.addr == UMF_OFS_IRQ_ENABLE)
            begin
                irq_en_reg <= bus_i.wdata[UMF_IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(irq_sts_reg & irq_en_reg);

    // pins idle high; loop-back keeps them quiet toward the modem
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            rts_pin_reg <= 1'b1;
            dtr_pin_reg <= 1'b1;
            op1_pin_reg <= 1'b1;
            op2_pin_reg <= 1'b1;
        end
        else
        begin
            // hold clears in the cycle after auto rts is switched off
            rts_pin_reg <= loop_mode || !(mcr_reg[UMF_MCR_RTS] && !rts_hold);
            dtr_pin_reg <= loop_mode || !mcr_reg[UMF_MCR_DTR];
            op1_pin_reg <= loop_mode || !mcr_reg[UMF_MCR_OP1];
            op2_pin_reg <= loop_mode || !mcr_reg[UMF_MCR_OP2];
        end
    end

    assign rts_pin_o = rts_pin_reg;
    assign dtr_pin_o = dtr_pin_reg;
    assign op1_pin_o = op1_pin_reg;
    assign op2_pin_o = op2_pin_reg;

    // a character already in flight is the transmitter's to finish
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            tx_hold_reg <= 1'b0;
        end
        else
        begin
            tx_hold_reg <= feature_reg[UMF_FEAT_AUTO_CTS] && !line_act[UMF_LN_CTS];
        end
    end

    assign tx_hold_o = tx_hold_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            rdata_reg <= UMF_ZERO8;
        end
        else if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                UMF_OFS_MODEM_STATUS: rdata_reg <= {line_act, flag_reg};
                UMF_OFS_SCRATCH:      rdata_reg <= scratch_reg;
                UMF_OFS_ENH_FEATURE:  rdata_reg <= feature_reg;
                UMF_OFS_MODEM_CTRL:   rdata_reg <= mcr_reg;
                UMF_OFS_RESUME_ONE:   rdata_reg <= resume_one_reg;
                UMF_OFS_RESUME_TWO:   rdata_reg <= resume_two_reg;
                UMF_OFS_PAUSE_ONE:    rdata_reg <= pause_one_reg;
                UMF_OFS_PAUSE_TWO:    rdata_reg <= pause_two_reg;
                UMF_OFS_FIFO_CTRL:    rdata_reg <= {6'h00, trig_sel_reg};
                UMF_OFS_IRQ_STATUS:   rdata_reg <= {6'h00, irq_sts_reg};
                UMF_OFS_IRQ_ENABLE:   rdata_reg <= {6'h00, irq_en_reg};
                default:              rdata_reg <= UMF_ZERO8;
            endcase
        end
        else
        begin
            rdata_reg <= UMF_ZERO8;
        end
    end

    assign rdata_o = rdata_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_CHANGE_SETS_FLAG: assert property (
        (line_act[UMF_LN_DSR] != line_prev_reg[UMF_LN_DSR])
        |=> flag_reg[UMF_LN_DSR])
        else $error("dsr change flag not set");
    AST_MODEM_IRQ_LEVEL: assert property (
        (chg_evt != 4'h0) |=> (modem_irq_o && irq_sts_reg[UMF_IRQ_MODEM]))
        else $error("modem interrupt low with a flag set");
    AST_SCRATCH_READBACK: assert property (
        (bus_i.wr && bus_i.addr == UMF_OFS_SCRATCH)
        ##1 (bus_i.rd && bus_i.addr == UMF_OFS_SCRATCH && !bus_i.wr)
        |=> (rdata_o == $past(bus_i.wdata, 2)))
        else $error("scratch byte did not read back");
    AST_CTS_STOPS_TX: assert property (
        (feature_reg[UMF_FEAT_AUTO_CTS] && !loop_mode && pin_level[UMF_LN_CTS])
        |=> tx_hold_o)
        else $error("transmitter not held with cts high");
    AST_CTS_RESUMES_TX: assert property (
        (!pin_level[UMF_LN_CTS] && !loop_mode) |=> !tx_hold_o)
        else $error("transmitter held with cts low");
    AST_RXTRIG_IRQ: assert property (
        (trig_hit && !trig_prev_reg) |=> irq_sts_reg[UMF_IRQ_RXTRIG])
        else $error("trigger interrupt not latched");
    AST_RTS_FOLLOWS_SW: assert property (
        (!feature_reg[UMF_FEAT_AUTO_RTS] && !rts_hold && !loop_mode)
        |=> (rts_pin_o == !$past(mcr_reg[UMF_MCR_RTS])))
        else $error("rts pin ignores software bit");
    AST_RESET_ENABLES_ZERO: assert property (
        disable iff (1'b0) sys_rst_i
        |=> ({feature_reg[UMF_FEAT_AUTO_CTS], feature_reg[UMF_FEAT_AUTO_RTS]} == 2'h0))
        else $error("flow enables not cleared by reset");
    AST_READ_CLEARS_FLAGS: assert property (
        (status_rd && chg_evt == 4'h0) |=> (flag_reg == 4'h0))
        else $error("status read left flags set");
    AST_CTS_STATUS_BIT: assert property (
        (bus_i.rd && bus_i.addr == UMF_OFS_MODEM_STATUS)
        |=> (rdata_o[4] == ($past(loop_mode) ? $past(mcr_reg[UMF_MCR_RTS])
                                             : !$past(pin_level[UMF_LN_CTS]))))
        else $error("cts status bit wrong");
    AST_IRQ_HOLDS_TO_READ: assert property (
        (modem_irq_o && !status_rd) |=> modem_irq_o)
        else $error("modem interrupt dropped without a read");

    COV_FLAG_THEN_READ: cover property (modem_irq_o ##[1:50] status_rd);
    COV_CTS_GATE: cover property (tx_hold_o ##[1:100] !tx_hold_o);
    COV_RXTRIG: cover property (irq_evt[UMF_IRQ_RXTRIG] ##1 irq_o);
endmodule : umf_modem_flow
`default_nettype wire

// File: design/umf_pkg.sv
package umf_pkg;
    localparam int unsigned UMF_LINES = 4;
    localparam int unsigned UMF_FILL_W = 5;
    // register indices on the parallel port
    localparam logic [3:0] UMF_OFS_MODEM_STATUS = 4'h0;
    localparam logic [3:0] UMF_OFS_SCRATCH      = 4'h1;
    localparam logic [3:0] UMF_OFS_ENH_FEATURE  = 4'h2;
    localparam logic [3:0] UMF_OFS_MODEM_CTRL   = 4'h3;
    localparam logic [3:0] UMF_OFS_RESUME_ONE   = 4'h4;
    localparam logic [3:0] UMF_OFS_RESUME_TWO   = 4'h5;
    localparam logic [3:0] UMF_OFS_PAUSE_ONE    = 4'h6;
    localparam logic [3:0] UMF_OFS_PAUSE_TWO    = 4'h7;
    localparam logic [3:0] UMF_OFS_FIFO_CTRL    = 4'h8;
    localparam logic [3:0] UMF_OFS_IRQ_STATUS   = 4'h9;
    localparam logic [3:0] UMF_OFS_IRQ_CLEAR    = 4'hA;
    localparam logic [3:0] UMF_OFS_IRQ_ENABLE   = 4'hB;
    // reset values
    localparam logic [7:0] UMF_SCRATCH_RST = 8'hFF;
    localparam logic [7:0] UMF_ZERO8       = 8'h00;
    // enhanced feature control fields
    localparam int UMF_FEAT_AUTO_CTS = 7;
    localparam int UMF_FEAT_AUTO_RTS = 6;
    localparam int UMF_FEAT_ENH_EN   = 4;
    // modem control fields
    localparam int UMF_MCR_DTR  = 0;
    localparam int UMF_MCR_RTS  = 1;
    localparam int UMF_MCR_OP1  = 2;
    localparam int UMF_MCR_OP2  = 3;
    localparam int UMF_MCR_LOOP = 4;
    // line positions in the status byte, low nibble and high nibble alike
    localparam int UMF_LN_CTS = 0;
    localparam int UMF_LN_DSR = 1;
    localparam int UMF_LN_RI  = 2;
    localparam int UMF_LN_CD  = 3;
    // interrupt status bits
    localparam int UMF_IRQ_W      = 2;
    localparam int UMF_IRQ_MODEM  = 0;
    localparam int UMF_IRQ_RXTRIG = 1;
    // receive trigger levels, indexed by the 2-bit selector
    localparam logic [3:0][4:0] UMF_TRIG_LVL   = {5'h0E, 5'h08, 5'h04, 5'h01};
    localparam logic [3:0][4:0] UMF_TRIG_ABOVE = {5'h10, 5'h0E, 5'h08, 5'h04};
    localparam logic [3:0][4:0] UMF_TRIG_BELOW = {5'h08, 5'h04, 5'h01, 5'h01};

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } umf_bus_req_s;

    typedef enum logic [0:0] {
        UMF_RTS_OPEN = 1'b0,
        UMF_RTS_HELD = 1'b1
    } umf_rts_state_e;
endpackage : umf_pkg

// File: design/umf_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module umf_pin_sync
(
    input  wire logic                          ref_clk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic [umf_pkg::UMF_LINES-1:0] pin_i,
    output logic      [umf_pkg::UMF_LINES-1:0] level_o
);
    import umf_pkg::*;

    for (genvar i = 0; i < UMF_LINES; i++)
    begin : g_bit
        logic s1_reg;
        logic s2_reg;
        logic s3_reg;
        logic lvl_reg;
        // idle lines sit high; a level only moves once two stages agree
        always_ff @(posedge ref_clk_i)
        begin
            if (sys_rst_i)
            begin
                s1_reg  <= 1'b1;
                s2_reg  <= 1'b1;
                s3_reg  <= 1'b1;
                lvl_reg <= 1'b1;
            end
            else
            begin
                s1_reg <= pin_i[i];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                if (s2_reg == s3_reg)
                begin
                    lvl_reg <= s3_reg;
                end
            end
        end
        assign level_o[i] = lvl_reg;
    end
endmodule : umf_pin_sync
`default_nettype wire

// File: design/umf_rts_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module umf_rts_ctrl
(
    input  wire logic                           ref_clk_i,
    input  wire logic                           sys_rst_i,
    input  wire logic                           enable_i,
    input  wire logic [1:0]                     trig_sel_i,
    input  wire logic [umf_pkg::UMF_FILL_W-1:0] fill_i,
    output logic                                trig_hit_o,
    output logic                                hold_o
);
    import umf_pkg::*;

    umf_rts_state_e state_reg;
    umf_rts_state_e state_next;
    logic [4:0]     lvl;
    logic [4:0]     above;
    logic [4:0]     below;

    assign lvl   = UMF_TRIG_LVL[trig_sel_i];
    assign above = UMF_TRIG_ABOVE[trig_sel_i];
    assign below = UMF_TRIG_BELOW[trig_sel_i];
    assign trig_hit_o = enable_i && (fill_i >= lvl);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            UMF_RTS_OPEN:
            begin
                if (enable_i && (fill_i >= above))
                begin
                    state_next = UMF_RTS_HELD;
                end
            end
            UMF_RTS_HELD:
            begin
                // dropping the enable releases the line at once
                if (!enable_i || (fill_i < below))
                begin
                    state_next = UMF_RTS_OPEN;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= UMF_RTS_OPEN;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign hold_o = (state_reg == UMF_RTS_HELD);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_RTS_HOLD_AT_ABOVE: assert property (
        (enable_i && fill_i >= above) |=> hold_o)
        else $error("rts not held at next trigger level");
    AST_RTS_RELEASE_BELOW: assert property (
        (enable_i && fill_i < below) |=> !hold_o)
        else $error("rts not released below lower level");
    AST_RTS_OFF_NO_HOLD: assert property (
        (!enable_i ##1 !enable_i) |-> !hold_o)
        else $error("rts held with auto control off");
    COV_RTS_CYCLE: cover property (!hold_o ##1 hold_o ##[1:200] !hold_o);
endmodule : umf_rts_ctrl
`default_nettype wire

// File: tb/umf_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module umf_modem_model
(
    input  wire logic ref_clk_i,
    output logic      cts_pin_o,
    output logic      dsr_pin_o,
    output logic      ri_pin_o,
    output logic      cd_pin_o
);
    // lines are active low and sit deasserted until the bench asserts them
    logic [3:0] line_reg = 4'hF;

    assign {cd_pin_o, ri_pin_o, dsr_pin_o, cts_pin_o} = line_reg;

    task set_lines(input logic [3:0] act);
        @(posedge ref_clk_i);
        line_reg <= ~act;
    endtask : set_lines
endmodule : umf_modem_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb;
    import umf_pkg::*;
    logic         ref_clk_i = 1'b0;
    logic         sys_rst_i;
    umf_bus_req_s bus;
    logic [4:0]   fill;
    logic [7:0]   rdata, rv, d;
    logic         cts, dsr, ri, cd, rts, dtr, op1, op2, hold, mirq, irq, enh;
    logic [1:0]   txm, rxm;
    logic [15:0]  rseq, pseq;
    int           num_errors = 0;
    int           num_checks = 0;
    int           seed = 32'h5d8970e7;

    always #4 ref_clk_i = ~ref_clk_i;

    umf_modem_model modem_u (.ref_clk_i(ref_clk_i), .cts_pin_o(cts), .dsr_pin_o(dsr),
        .ri_pin_o(ri), .cd_pin_o(cd));

    umf_modem_flow dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
        .rdata_o(rdata), .cts_pin_i(cts), .dsr_pin_i(dsr), .ri_pin_i(ri), .cd_pin_i(cd),
        .rx_fill_i(fill), .rts_pin_o(rts), .dtr_pin_o(dtr), .op1_pin_o(op1), .op2_pin_o(op2),
        .tx_hold_o(hold), .modem_irq_o(mirq), .irq_o(irq), .tx_sw_mode_o(txm),
        .rx_sw_mode_o(rxm), .enh_enable_o(enh), .resume_seq_o(rseq), .pause_seq_o(pseq));

    task conclude();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    // called just after an edge, so back-to-back calls give strobes with no gap
    task wr(input logic [3:0] a, input logic [7:0] v);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
        bus.wr <= 1'b0;
        #1;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] v);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task put_fill(input logic [4:0] v);
        @(posedge ref_clk_i);
        fill <= v;
    endtask : put_fill

    function logic [7:0] exp_status(input logic [3:0] act, input logic [3:0] flg);
        return {act, flg};
    endfunction : exp_status

    function logic pick(input int sel);
        case (sel)
            0: return hold;
            1: return rts;
            2: return mirq;
            default: return irq;
        endcase
    endfunction : pick

    // bounded wait; running out counts once and ends the run
    task wait_out(input string nm, input int sel, input logic val);
        int n;
        n = 0;
        while (pick(sel) !== val && n < 20)
        begin
            @(posedge ref_clk_i);
            #1 n++;
        end
        `CHK(nm, val, pick(sel))
        if (pick(sel) !== val)
            conclude();
    endtask : wait_out

    task settle_chk(input string nm, input int sel, input logic val);
        repeat (4) @(posedge ref_clk_i);
        #1 `CHK(nm, val, pick(sel))
    endtask : settle_chk

    initial
    begin
        sys_rst_i = 1'b1;
        bus = '0;
        fill = '0;
        repeat (3) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd(UMF_OFS_SCRATCH, rv);
        `CHK("scratch rst", UMF_SCRATCH_RST, rv)
        rd(UMF_OFS_ENH_FEATURE, rv);
        `CHK("feature rst", 8'h00, rv)
        `CHK("hold rst", 1'b0, hold)
        $display("test reset done");
        repeat (8)
        begin
            d = 8'($random(seed));
            wr(4'hF, ~d);
            wr(UMF_OFS_SCRATCH, d);
            rd(UMF_OFS_SCRATCH, rv);
            `CHK("scratch", d, rv)
            rd(4'hF, rv);
            `CHK("unmapped", 8'h00, rv)
        end
        $display("test scratch done");
        wr(UMF_OFS_IRQ_ENABLE, 8'h03);
        modem_u.set_lines(4'b0010);
        wait_out("modem irq", 2, 1'b1);
        `CHK("irq dsr", 1'b1, irq)
        rd(UMF_OFS_MODEM_STATUS, rv);
        `CHK("status dsr", 8'h22, rv)
        `CHK("modem irq clr", 1'b0, mirq)
        rd(UMF_OFS_MODEM_STATUS, rv);
        `CHK("status reread", 8'h20, rv)
        wr(UMF_OFS_IRQ_CLEAR, 8'h01);
        `CHK("irq clr", 1'b0, irq)
        modem_u.set_lines(4'b0011);
        wait_out("modem irq", 2, 1'b1);
        rd(UMF_OFS_MODEM_STATUS, rv);
        `CHK("status cts", 8'h31, rv)
        modem_u.set_lines(4'h7);
        repeat (6) @(posedge ref_clk_i);
        rd(UMF_OFS_MODEM_STATUS, rv);
        `CHK("ri lead", exp_status(4'h7, 4'h0), rv)
        modem_u.set_lines(4'h3);
        wait_out("ri trail irq", 2, 1'b1);
        rd(UMF_OFS_MODEM_STATUS, rv);
        `CHK("ri trail", exp_status(4'h3, 4'h4), rv)
        $display("test change flags done");
        wr(UMF_OFS_MODEM_CTRL, 8'h12);
        repeat (6) @(posedge ref_clk_i);
        rd(UMF_OFS_MODEM_STATUS, rv);
        `CHK("loop status", 4'h1, rv[7:4])
        `CHK("loop pins", 4'hF, {op2, op1, dtr, rts})
        wr(UMF_OFS_MODEM_CTRL, 8'h02);
        repeat (6) @(posedge ref_clk_i);
        rd(UMF_OFS_MODEM_STATUS, rv);
        `CHK("loop exit", exp_status(4'h3, 4'h2), rv)
        $display("test loopback done");
        wr(UMF_OFS_ENH_FEATURE, 8'h80);
        modem_u.set_lines(4'b0010);
        wait_out("tx hold", 0, 1'b1);
        modem_u.set_lines(4'b0011);
        wait_out("tx free", 0, 1'b0);
        $display("test auto cts done");
        wr(UMF_OFS_IRQ_ENABLE, 8'h02);
        wr(UMF_OFS_IRQ_CLEAR, 8'h03);
        wr(UMF_OFS_ENH_FEATURE, 8'h40);
        for (int s = 0; s < 4; s++)
        begin
            wr(UMF_OFS_FIFO_CTRL, 8'(s));
            put_fill(UMF_TRIG_LVL[s]);
            wait_out("trig irq", 3, 1'b1);
            put_fill(UMF_TRIG_ABOVE[s] - 5'h01);
            settle_chk("rts early", 1, 1'b0);
            put_fill(UMF_TRIG_ABOVE[s]);
            wait_out("rts held", 1, 1'b1);
            put_fill(UMF_TRIG_BELOW[s]);
            settle_chk("rts kept", 1, 1'b1);
            put_fill(UMF_TRIG_BELOW[s] - 5'h01);
            wait_out("rts freed", 1, 1'b0);
            wr(UMF_OFS_IRQ_CLEAR, 8'h02);
            `CHK("trig clr", 1'b0, irq)
        end
        $display("test auto rts done");
        wr(UMF_OFS_ENH_FEATURE, 8'h00);
        put_fill(5'h10);
        settle_chk("rts manual", 1, 1'b0);
        wr(UMF_OFS_MODEM_CTRL, 8'h00);
        wait_out("rts off", 1, 1'b1);
        wr(UMF_OFS_MODEM_CTRL, 8'h0D);
        @(posedge ref_clk_i);
        #1 `CHK("ctrl pins", 4'h1, {op2, op1, dtr, rts})
        put_fill(5'h00);
        $display("test manual rts done");
        wr(UMF_OFS_ENH_FEATURE, 8'h1B);
        for (int i = 0; i < 4; i++)
            wr(UMF_OFS_RESUME_ONE + 4'(i), 8'hA0 + 8'(i));
        `CHK("tx mode", 2'b10, txm)
        `CHK("rx mode", 2'b11, rxm)
        `CHK("enh", 1'b1, enh)
        `CHK("resume seq", 16'hA0A1, rseq)
        `CHK("pause seq", 16'hA2A3, pseq)
        $display("test sw flow done");
        conclude();
    end
endmodule : tb
`default_nettype wire
